// *** hdl/grp_regs.sv ***
// Operation
// [R1] profile 0 endpoint register keeps start gain in bits 15-8, reset 00.
// [R2] profile 0 endpoint register keeps stop gain in bits 7-0, reset 9F.
// [R3] profile 0 step register keeps the up step in bits 15-8, reset 00.
// [R4] profile 0 step register keeps the down step in bits 7-0, reset FF.
// [R5] profile 0 index register keeps the first table index in bits 15-8, reset 00.
// [R6] profile 0 index register keeps the last table index in bits 7-0, reset 9F.
// [R7] profile 0 ramp start time is a 16-bit register, reset 0000.
// [R8] profile 0 gain hold time is a 16-bit register, reset 0000.
// [R9] profile 1 endpoint register keeps start gain in bits 15-8, reset 00.
// [R10] profile 1 endpoint register keeps stop gain in bits 7-0, reset 9F.
// [R11] writes to the ramp registers are ignored unless the unlock bit is one.
// [R12] a read returns the last value written, or the reset value.
`timescale 1ns/100ps
`default_nettype none

module grp_regs
    import grp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [GRP_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    output grp_profile_s               profile0,
    output grp_endpoints_s             profile1,
    output logic                       gain_table_write_unlock
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // word index of a byte address; misaligned addresses never match
    function automatic logic [8:0] word_index(input logic [GRP_ADDR_W-1:0] a);
        word_index = (a[1:0] == 2'b00) ? {1'b0, a[GRP_ADDR_W-1:2]} : 9'h1FF;
    endfunction

    // true when the address hits the given register index
    function automatic logic hits(input logic [GRP_ADDR_W-1:0] a, input logic [7:0] idx);
        hits = (word_index(a) == {1'b0, idx});
    endfunction

    logic       access;
    logic       wr_strobe;
    logic       mapped;
    logic       ramp_wr_ok;
    logic [5:0] sel_ramp;
    logic       sel_unlock;
    logic [15:0] wr_word;

    // zero-wait slave: the access phase completes in its first cycle
    assign access    = psel && penable;
    assign wr_strobe = access && pwrite;

    always_comb begin
        sel_ramp[0] = hits(paddr, GRP_IDX_P0_ENDPOINTS);
        sel_ramp[1] = hits(paddr, GRP_IDX_P0_STEPS);
        sel_ramp[2] = hits(paddr, GRP_IDX_P0_INDICES);
        sel_ramp[3] = hits(paddr, GRP_IDX_P0_START_TIME);
        sel_ramp[4] = hits(paddr, GRP_IDX_P0_HOLD_TIME);
        sel_ramp[5] = hits(paddr, GRP_IDX_P1_ENDPOINTS);
    end

    assign sel_unlock = hits(paddr, GRP_IDX_UNLOCK);
    assign mapped     = (|sel_ramp) || sel_unlock;

    // byte lanes 0 and 1 carry the 16-bit register; an unstrobed lane keeps old data
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------
    // write unlock
    // ------------------------------------------------------------
    logic unlock_r;

    // software gate for the ramp registers; resets locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_r <= 1'b0;
        end else if (wr_strobe && sel_unlock && pstrb[0]) begin
            unlock_r <= pwdata[GRP_UNLOCK_BIT];
        end
    end

    assign gain_table_write_unlock = unlock_r;

    // a locked write is accepted on the bus but changes nothing
    assign ramp_wr_ok = wr_strobe && unlock_r; // [R11]

    // ------------------------------------------------------------
    // ramp parameter registers
    // ------------------------------------------------------------
    logic [15:0] p0_endpoints;
    logic [15:0] p0_steps;
    logic [15:0] p0_indices;
    logic [15:0] p0_start_time;
    logic [15:0] p0_hold_time;
    logic [15:0] p1_endpoints;
    logic [15:0] cur_word;

    // current value of the addressed register, for partial-lane merge
    always_comb begin
        unique case (1'b1)
            sel_ramp[0]: cur_word = p0_endpoints;
            sel_ramp[1]: cur_word = p0_steps;
            sel_ramp[2]: cur_word = p0_indices;
            sel_ramp[3]: cur_word = p0_start_time;
            sel_ramp[4]: cur_word = p0_hold_time;
            sel_ramp[5]: cur_word = p1_endpoints;
            default:     cur_word = 16'h0000;
        endcase
    end

    assign wr_word = merge(cur_word, pwdata, pstrb);

    // start gain high byte, stop gain low byte
    grp_field16 #(
        .RESET_VALUE ({GRP_RST_START_GAIN, GRP_RST_STOP_GAIN}) // [R1] [R2]
    ) u_p0_endpoints (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ramp_wr_ok && sel_ramp[0]), // [R11]
        .wr_data (wr_word),
        .value   (p0_endpoints)
    );

    // up step high byte, down step low byte
    grp_field16 #(
        .RESET_VALUE ({GRP_RST_UP_STEP, GRP_RST_DOWN_STEP}) // [R3] [R4]
    ) u_p0_steps (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ramp_wr_ok && sel_ramp[1]),
        .wr_data (wr_word),
        .value   (p0_steps)
    );

    // first index high byte, last index low byte
    grp_field16 #(
        .RESET_VALUE ({GRP_RST_START_INDEX, GRP_RST_STOP_INDEX}) // [R5] [R6]
    ) u_p0_indices (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ramp_wr_ok && sel_ramp[2]),
        .wr_data (wr_word),
        .value   (p0_indices)
    );

    // full-width ramp start time
    grp_field16 #(
        .RESET_VALUE (GRP_RST_TIME) // [R7]
    ) u_p0_start_time (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ramp_wr_ok && sel_ramp[3]),
        .wr_data (wr_word),
        .value   (p0_start_time)
    );

    // full-width gain hold time
    grp_field16 #(
        .RESET_VALUE (GRP_RST_TIME) // [R8]
    ) u_p0_hold_time (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ramp_wr_ok && sel_ramp[4]),
        .wr_data (wr_word),
        .value   (p0_hold_time)
    );

    // profile 1 start and stop gain
    grp_field16 #(
        .RESET_VALUE ({GRP_RST_START_GAIN, GRP_RST_STOP_GAIN}) // [R9] [R10]
    ) u_p1_endpoints (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ramp_wr_ok && sel_ramp[5]),
        .wr_data (wr_word),
        .value   (p1_endpoints)
    );

    // ------------------------------------------------------------
    // outputs to the ramp engine
    // ------------------------------------------------------------
    always_comb begin
        profile0.start_gain  = p0_endpoints[GRP_HI_LSB +: 8]; // [R1]
        profile0.stop_gain   = p0_endpoints[GRP_LO_LSB +: 8]; // [R2]
        profile0.up_step     = p0_steps[GRP_HI_LSB +: 8];     // [R3]
        profile0.down_step   = p0_steps[GRP_LO_LSB +: 8];     // [R4]
        profile0.start_index = p0_indices[GRP_HI_LSB +: 8];   // [R5]
        profile0.stop_index  = p0_indices[GRP_LO_LSB +: 8];   // [R6]
        profile0.start_time  = p0_start_time;                 // [R7]
        profile0.hold_time   = p0_hold_time;                  // [R8]
        profile1.start_gain  = p1_endpoints[GRP_HI_LSB +: 8]; // [R9]
        profile1.stop_gain   = p1_endpoints[GRP_LO_LSB +: 8]; // [R10]
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;

    // registered read data; upper 16 bits always read zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (sel_unlock) begin
            rd_nxt[GRP_UNLOCK_BIT] = unlock_r;
        end else if (|sel_ramp) begin
            rd_nxt[15:0] = cur_word; // [R12]
        end
    end

    // captured in the setup cycle so the access phase sees stable data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    // unmapped or misaligned addresses answer with an error and do nothing
    assign pslverr = access && !mapped;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_locked_write_held: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (wr_strobe && !unlock_r && |sel_ramp) |=> $stable(profile0) && $stable(profile1))
        else $error("ramp register changed while write unlock was clear");

    a_p0_end_write: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (ramp_wr_ok && sel_ramp[0] && pstrb[1:0] == 2'b11)
        |=> profile0.start_gain == $past(pwdata[15:8]))
        else $error("profile 0 start gain did not take written value");

    a_p0_stop_write: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (ramp_wr_ok && sel_ramp[0] && pstrb[0]) |=> profile0.stop_gain == $past(pwdata[7:0]))
        else $error("profile 0 stop gain did not take written value");

    a_p0_step_write: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        (ramp_wr_ok && sel_ramp[1] && pstrb[1]) |=> profile0.up_step == $past(pwdata[15:8]))
        else $error("profile 0 up step did not take written value");

    a_p0_down_write: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        (ramp_wr_ok && sel_ramp[1] && pstrb[0]) |=> profile0.down_step == $past(pwdata[7:0]))
        else $error("profile 0 down step did not take written value");

    a_p0_index_write: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        (ramp_wr_ok && sel_ramp[2] && pstrb[1]) |=> profile0.start_index == $past(pwdata[15:8]))
        else $error("profile 0 first index did not take written value");

    a_p0_last_write: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        (ramp_wr_ok && sel_ramp[2] && pstrb[0]) |=> profile0.stop_index == $past(pwdata[7:0]))
        else $error("profile 0 last index did not take written value");

    a_p0_time_write: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        (ramp_wr_ok && sel_ramp[3] && pstrb[1:0] == 2'b11)
        |=> profile0.start_time == $past(pwdata[15:0]))
        else $error("profile 0 start time did not take written value");

    a_p0_hold_write: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (ramp_wr_ok && sel_ramp[4] && pstrb[1:0] == 2'b11)
        |=> profile0.hold_time == $past(pwdata[15:0]))
        else $error("profile 0 hold time did not take written value");

    a_p1_end_write: assert property (@(posedge pclk) disable iff (!presetn) // [R9] [R10]
        (ramp_wr_ok && sel_ramp[5] && pstrb[1:0] == 2'b11)
        |=> {profile1.start_gain, profile1.stop_gain} == $past(pwdata[15:0]))
        else $error("profile 1 endpoints did not take written value");

    a_read_matches: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (psel && !penable && !pwrite && sel_ramp[3] && !ramp_wr_ok)
        |=> prdata == {16'h0000, profile0.start_time})
        else $error("read data does not match start time register");

    // the unlock bit moves only on its own strobed write
    a_unlock_write: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (wr_strobe && sel_unlock && pstrb[0])
        |=> gain_table_write_unlock == $past(pwdata[GRP_UNLOCK_BIT]))
        else $error("write unlock bit did not take written value");

    a_unlock_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        !(wr_strobe && sel_unlock && pstrb[0]) |=> $stable(gain_table_write_unlock))
        else $error("write unlock bit changed without a write");

    // nothing but an accepted write may move a ramp register
    a_regs_idle_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !ramp_wr_ok |=> $stable(profile0) && $stable(profile1))
        else $error("ramp register changed without an accepted write");

    // an unstrobed lane keeps its old byte
    a_lane_keep_high: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (ramp_wr_ok && sel_ramp[0] && !pstrb[1]) |=> $stable(profile0.start_gain))
        else $error("profile 0 start gain changed on an unstrobed lane");

    a_lane_keep_low: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (ramp_wr_ok && sel_ramp[5] && !pstrb[0]) |=> $stable(profile1.stop_gain))
        else $error("profile 1 stop gain changed on an unstrobed lane");

    // read data shown in the access phase mirrors the addressed register
    a_read_endpoints: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (psel && !penable && !pwrite && sel_ramp[0])
        |=> prdata == {16'h0000, profile0.start_gain, profile0.stop_gain})
        else $error("read data does not match profile 0 endpoints");

    a_read_profile1: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (psel && !penable && !pwrite && sel_ramp[5])
        |=> prdata == {16'h0000, profile1.start_gain, profile1.stop_gain})
        else $error("read data does not match profile 1 endpoints");

    a_read_unlock: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (psel && !penable && !pwrite && sel_unlock) |=> prdata[0] == gain_table_write_unlock)
        else $error("read data does not match write unlock bit");

    a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (psel && !penable && !pwrite) |=> prdata[31:16] == 16'h0000)
        else $error("upper half of read data is not zero");

    c_unlocked_write: cover property (@(posedge pclk) disable iff (!presetn)
        ramp_wr_ok && |sel_ramp);
    c_locked_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_strobe && !unlock_r && |sel_ramp);
    c_ramp_read: cover property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && |sel_ramp);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
    c_lane_write: cover property (@(posedge pclk) disable iff (!presetn)
        ramp_wr_ok && |sel_ramp && pstrb[1:0] != 2'b11);

endmodule

`default_nettype wire

// *** hdl/grp_pkg.sv ***
`default_nettype none

package grp_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] GRP_IDX_P0_ENDPOINTS = 8'hA1;
    localparam logic [7:0] GRP_IDX_P0_STEPS     = 8'hA2;
    localparam logic [7:0] GRP_IDX_P0_INDICES   = 8'hA3;
    localparam logic [7:0] GRP_IDX_P0_START_TIME = 8'hA4;
    localparam logic [7:0] GRP_IDX_P0_HOLD_TIME = 8'hA5;
    localparam logic [7:0] GRP_IDX_P1_ENDPOINTS = 8'hA6;
    localparam logic [7:0] GRP_IDX_UNLOCK       = 8'hC0;

    localparam int GRP_ADDR_W = 10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int GRP_HI_LSB = 8;
    localparam int GRP_LO_LSB = 0;
    localparam int GRP_UNLOCK_BIT = 0;
    localparam logic [7:0]  GRP_RST_START_GAIN  = 8'h00;
    localparam logic [7:0]  GRP_RST_STOP_GAIN   = 8'h9F;
    localparam logic [7:0]  GRP_RST_UP_STEP     = 8'h00;
    localparam logic [7:0]  GRP_RST_DOWN_STEP   = 8'hFF;
    localparam logic [7:0]  GRP_RST_START_INDEX = 8'h00;
    localparam logic [7:0]  GRP_RST_STOP_INDEX  = 8'h9F;
    localparam logic [15:0] GRP_RST_TIME        = 16'h0000;

    // one gain profile's parameters as seen by the ramp engine
    typedef struct packed {
        logic [7:0]  start_gain;
        logic [7:0]  stop_gain;
        logic [7:0]  up_step;
        logic [7:0]  down_step;
        logic [7:0]  start_index;
        logic [7:0]  stop_index;
        logic [15:0] start_time;
        logic [15:0] hold_time;
    } grp_profile_s;

    // profile 1 endpoints only
    typedef struct packed {
        logic [7:0] start_gain;
        logic [7:0] stop_gain;
    } grp_endpoints_s;

endpackage

`default_nettype wire

// *** hdl/grp_field16.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// one 16-bit read/write register with its own reset value
// ----------------------------------------------------------------
module grp_field16
    import grp_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    output var  logic [15:0] value
);

    logic [15:0] value_r;

    // load on a qualified write, else hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_r <= RESET_VALUE;
        end else if (wr_en) begin
            value_r <= wr_data;
        end
    end

    assign value = value_r;

endmodule

`default_nettype wire

// *** tb/grp_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module grp_regs_tb
    import grp_pkg::*;
;
    // ------------------------------------------------------------
    // signals and scoreboard state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic [31:0] data;
        logic        err;
    } grp_note_s;

    localparam int TIMEOUT_CYCLES = 5000;

    logic                  pclk = 1'b0;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [GRP_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    logic [3:0]            pstrb;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    grp_profile_s          profile0;
    grp_endpoints_s        profile1;
    logic                  gain_table_write_unlock;

    grp_note_s             notes[$];
    grp_note_s             n;
    logic [15:0]           m [0:5];
    logic                  ul;
    logic [7:0]            idx [0:5];
    int                    miscompares = 0;
    int                    checks_done = 0;
    int                    cycles = 0;
    int                    k;
    int                    r;

    grp_regs u_dut (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .pstrb                   (pstrb),
        .pready                  (pready),
        .prdata                  (prdata),
        .pslverr                 (pslverr),
        .profile0                (profile0),
        .profile1                (profile1),
        .gain_table_write_unlock (gain_table_write_unlock)
    );

    // clock and hang guard; the guard ends the run through the same report
    always #25 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------
    // monitor: each completed transfer retires the oldest note
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            `CHK(notes.size() > 0, 1'b1)
            n = notes.pop_front();
            `CHK(pslverr, n.err)
            if (n.rd) begin
                `CHK(prdata, n.data)
            end
        end
    end

    // ------------------------------------------------------------
    // model, bus master and checks
    // ------------------------------------------------------------
    // reset image built from the field constants, not from the design
    task mreset;
        m[0] = {GRP_RST_START_GAIN, GRP_RST_STOP_GAIN};
        m[1] = {GRP_RST_UP_STEP, GRP_RST_DOWN_STEP};
        m[2] = {GRP_RST_START_INDEX, GRP_RST_STOP_INDEX};
        m[3] = GRP_RST_TIME;
        m[4] = GRP_RST_TIME;
        m[5] = {GRP_RST_START_GAIN, GRP_RST_STOP_GAIN};
        ul = 1'b0;
    endtask

    // note the expectation, update the model, then run setup and access
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        grp_note_s nt;
        int        j;
        nt = '{rd: !w, data: 32'h0000_0000, err: 1'b1};
        if (a == {GRP_IDX_UNLOCK, 2'b00}) begin
            nt.err = 1'b0;
            nt.data = {31'h0000_0000, ul};
            if (w && s[0]) ul = d[0];
        end
        for (j = 0; j < 6; j++) begin
            if (a == {idx[j], 2'b00}) begin
                nt.err = 1'b0;
                nt.data = {16'h0000, m[j]};
                if (w && ul && s[0]) m[j][7:0] = d[7:0];
                if (w && ul && s[1]) m[j][15:8] = d[15:8];
            end
        end
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        notes.push_back(nt);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // outputs are looked at mid-cycle so the access edge has landed
    task chk_out;
        @(negedge pclk);
        `CHK({profile0, profile1}, {m[0], m[1], m[2], m[3], m[4], m[5]})
        `CHK(gain_table_write_unlock, ul)
    endtask

    task results;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        idx = '{GRP_IDX_P0_ENDPOINTS, GRP_IDX_P0_STEPS, GRP_IDX_P0_INDICES,
                GRP_IDX_P0_START_TIME, GRP_IDX_P0_HOLD_TIME, GRP_IDX_P1_ENDPOINTS};
        mreset();
        r = $urandom(32'hA2CEDA4E);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk_out();
        for (k = 0; k < 6; k++) apb(1'b0, {idx[k], 2'b00}, $urandom, 4'h0);
        // locked writes complete without error and change nothing
        for (k = 0; k < 6; k++) apb(1'b1, {idx[k], 2'b00}, $urandom, 4'h3);
        apb(1'b1, {GRP_IDX_UNLOCK, 2'b00}, 32'h0000_0001, 4'h2);
        chk_out();
        apb(1'b1, {GRP_IDX_UNLOCK, 2'b00}, 32'h0000_0001, 4'h1);
        // full writes, then single lanes, each read back
        for (r = 0; r < 4; r++) begin
            for (k = 0; k < 6; k++) begin
                apb(1'b1, {idx[k], 2'b00}, $urandom, (r < 2) ? 4'hF : 4'h1 << (r - 2));
                apb(1'b0, {idx[k], 2'b00}, $urandom, 4'h0);
                chk_out();
            end
        end
        // unmapped and misaligned places answer with an error
        apb(1'b1, 10'h3FC, $urandom, 4'hF);
        apb(1'b0, 10'h3FC, $urandom, 4'h0);
        apb(1'b1, 10'h285, $urandom, 4'hF);
        apb(1'b0, 10'h285, $urandom, 4'h0);
        chk_out();
        // relock, then a write that must be dropped
        apb(1'b1, {GRP_IDX_UNLOCK, 2'b00}, 32'h0000_0000, 4'h1);
        apb(1'b1, {idx[0], 2'b00}, $urandom, 4'h3);
        apb(1'b0, {GRP_IDX_UNLOCK, 2'b00}, $urandom, 4'h0);
        apb(1'b0, {idx[0], 2'b00}, $urandom, 4'h0);
        chk_out();
        // second reset in mid-run restores every field
        apb(1'b1, {GRP_IDX_UNLOCK, 2'b00}, 32'h0000_0001, 4'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        mreset();
        repeat (2) @(posedge pclk);
        chk_out();
        // release on a rising edge like every other input change
        @(posedge pclk);
        presetn <= 1'b1;
        chk_out();
        for (k = 0; k < 6; k++) apb(1'b0, {idx[k], 2'b00}, $urandom, 4'h0);
        repeat (2) @(posedge pclk);
        `CHK(notes.size(), 0)
        results();
    end

endmodule

`default_nettype wire
